// ---- pkg/dcsd_map.vh ----
// Constants for the core scaling datapath: status fields, reset values, opcodes
`ifndef DCSD_MAP_VH
`define DCSD_MAP_VH

// ==========================================
// Status word zero fields
`define DCSD_S0_PTR_HI 15
`define DCSD_S0_PTR_LO 13
`define DCSD_S0_EXCESS 12
`define DCSD_S0_SATMODE 11
`define DCSD_S0_ONE 10
`define DCSD_S0_IRQDIS 9
`define DCSD_S0_PAGE_HI 8
`define DCSD_S0_PAGE_LO 0

// ==========================================
// Status word one fields
`define DCSD_S1_BKP_HI 15
`define DCSD_S1_BKP_LO 13
`define DCSD_S1_RAMMAP 12
`define DCSD_S1_TEST 11
`define DCSD_S1_SIGNEXT 10
`define DCSD_S1_CARRY 9
`define DCSD_S1_EXTFLAG 4
`define DCSD_S1_PSHIFT_HI 1
`define DCSD_S1_PSHIFT_LO 0

// ==========================================
// Reserved bits read as one
`define DCSD_S0_RSVD_MASK 16'h0400
`define DCSD_S1_RSVD_MASK 16'h01ec
`define DCSD_S0_RESET 16'h0600
`define DCSD_S1_RESET 16'h07fc

// ==========================================
// Product scaler modes
`define DCSD_PSHIFT_NONE 2'h0
`define DCSD_PSHIFT_LEFT1 2'h1
`define DCSD_PSHIFT_LEFT4 2'h2
`define DCSD_PSHIFT_RIGHT6 2'h3

// ==========================================
// Stack and trap vectors
`define DCSD_STACK_DEPTH 8
`define DCSD_TRAP_COUNT 32

// ==========================================
// Status operation codes
`define DCSD_SOP_NONE 3'h0
`define DCSD_SOP_LOAD0 3'h1
`define DCSD_SOP_LOAD1 3'h2
`define DCSD_SOP_SETBIT 3'h3
`define DCSD_SOP_CLRBIT 3'h4
`define DCSD_SOP_PTR 3'h5

`endif

// ---- verilog/dcsd_core.v ----
// Core scaling datapath: shifters, multiplier, address registers, stacks, status words
// What this block does
// RULE1: Input shifter left-shifts a 16-bit operand 0 to 16 into 32 bits, combinationally.
// RULE2: Multiplier forms a 32-bit product of two 16-bit operands in one cycle.
// RULE3: Multiplication is signed or unsigned, chosen per operation.
// RULE4: Output shifter left-shifts the 32-bit accumulator by 0 to 7.
// RULE5: Output drives the upper or lower half of the shifted value to write bus.
// RULE6: Product scaling is left 0, 1, 4 or right 6 bits.
// RULE7: Product scaling sits in the product path and adds no cycles.
// RULE8: Hardware stack holds eight 16-bit entries.
// RULE9: Operand register also gives shift count and bit index.
// RULE10: Next-fetch register holds the address for the following cycle.
// RULE11: Program counter increments the next-fetch address.
// RULE12: Current-fetch register holds its address while the bus cycle needs it.
// RULE13: Micro stack saves and restores next fetch address during data-space sequences.
// RULE14: Status word zero layout: pointer, excess, saturate, one, irq disable, page.
// RULE15: Status word one layout: backup, ram map, test, sign extend, carry, external flag, product mode.
// RULE16: Reserved status bits always read as one.
// RULE17: Load status writes the status words but leaves irq disable unchanged.
// RULE18: Store status copies either status word out to data memory.
// RULE19: Bit set and clear change single status bits only.
// RULE20: Thirty-two trap vectors reachable by hardware or software.
// RULE21: Loading the pointer, except by load status, copies old pointer to backup.
// RULE22: Irq disable is set by reset and by taking a maskable trap.
// RULE23: Saturate mode clamps overflowing accumulator; otherwise the result wraps.
// RULE24: Excess flag sets on overflow, held until reset, branch-on-overflow, load status or a bit operation on word zero.
// RULE25: One rising-edge clock; synchronous reset initialises status and stack pointer.
`timescale 1ns/1ps
`default_nettype none
`include "dcsd_map.vh"

module dcsd_core
(
	// Clock and reset
	input wire i_ref_clk,
	input wire i_rst,
	// Input scaler
	input wire [15:0] i_in_data,
	input wire [4:0] i_in_shift,
	input wire i_in_shift_by_opreg,
	input wire i_in_sign_ext,
	output wire [31:0] o_in_scaled,
	// Multiplier
	input wire i_opreg_load,
	input wire [15:0] i_opreg_data,
	input wire i_mul_go,
	input wire i_mul_signed,
	input wire [15:0] i_mul_data,
	output wire [15:0] o_opreg,
	output wire [3:0] o_bit_index,
	output reg [31:0] o_product_hold_r,
	output wire [31:0] o_product_scaled,
	// Accumulator result and saturation
	input wire [32:0] i_acc_sum,
	input wire i_acc_overflow,
	output reg [31:0] o_acc_r,
	// Output scaler
	input wire [2:0] i_out_shift,
	input wire i_out_high,
	output reg [15:0] o_write_data_r,
	// Program address
	input wire i_pa_advance,
	input wire i_pa_hold,
	input wire i_pa_jump,
	input wire [15:0] i_pa_target,
	input wire i_retstore_save,
	input wire i_retstore_restore,
	output reg [15:0] o_next_fetch_r,
	output reg [15:0] o_cur_fetch_r,
	// Hardware stack
	input wire i_stk_push,
	input wire i_stk_pop,
	input wire [15:0] i_stk_data,
	output wire [15:0] o_stk_top,
	output wire o_stk_empty,
	output wire o_stk_full,
	// Traps
	input wire i_trap_take,
	input wire [4:0] i_trap_num,
	input wire i_trap_maskable,
	output wire [15:0] o_trap_vector,
	// Status words
	input wire [2:0] i_stat_op,
	input wire i_stat_sel,
	input wire [3:0] i_stat_bit,
	input wire [15:0] i_stat_data,
	input wire i_branch_excess,
	input wire i_store_status,
	output reg [15:0] o_store_data_r,
	output wire [15:0] o_status0,
	output wire [15:0] o_status1,
	output wire o_external_flag_pin
);

	// ==========================================
	// Status storage
	reg [2:0] aux_pointer_select_r;
	reg [2:0] aux_pointer_backup_r;
	reg arith_excess_flag_r;
	reg saturate_mode_r;
	reg global_irq_disable_r;
	reg [8:0] page_pointer_r;
	reg ram_map_select_r;
	reg test_condition_flag_r;
	reg sign_extend_mode_r;
	reg carry_r;
	reg external_flag_r;
	reg [1:0] product_shift_mode_r;
	reg [15:0] multiplier_operand_reg_r;
	reg [15:0] micro_return_store_r;
	reg [15:0] stk_mem_r [0:`DCSD_STACK_DEPTH-1];
	reg [3:0] stk_cnt_r;
	integer k;

	// ==========================================
	// Status word images
	assign o_status0 = {aux_pointer_select_r, arith_excess_flag_r, saturate_mode_r, 1'b1, // RULE14
		global_irq_disable_r, page_pointer_r} | `DCSD_S0_RSVD_MASK; // RULE16
	assign o_status1 = {aux_pointer_backup_r, ram_map_select_r, test_condition_flag_r, // RULE15
		sign_extend_mode_r, carry_r, 4'hf, external_flag_r, 2'h3, product_shift_mode_r}
		| `DCSD_S1_RSVD_MASK; // RULE16
	assign o_external_flag_pin = external_flag_r;

	// ==========================================
	// Input scaler
	// Operand register gives only four bits, so its count stops at fifteen
	wire [4:0] in_opreg_amt = {1'b0, multiplier_operand_reg_r[3:0]};
	wire [4:0] in_amt = i_in_shift_by_opreg ? in_opreg_amt : i_in_shift; // RULE9
	wire in_sign = i_in_sign_ext & sign_extend_mode_r & i_in_data[15];
	wire [31:0] in_ext = {{16{in_sign}}, i_in_data};
	assign o_in_scaled = (in_amt > 5'h10) ? (in_ext << 16) : (in_ext << in_amt); // RULE1

	// ==========================================
	// Multiplier and product scaler
	assign o_opreg = multiplier_operand_reg_r;
	assign o_bit_index = multiplier_operand_reg_r[3:0]; // RULE9
	// A seventeenth bit carries the sign only for signed operations
	wire mul_a_sign = i_mul_signed & multiplier_operand_reg_r[15]; // RULE3
	wire mul_b_sign = i_mul_signed & i_mul_data[15];
	wire [16:0] mul_a = {mul_a_sign, multiplier_operand_reg_r};
	wire [16:0] mul_b = {mul_b_sign, i_mul_data};
	wire signed [33:0] mul_full = $signed(mul_a) * $signed(mul_b);
	wire [31:0] mul_prod = mul_full[31:0]; // RULE2

	reg [31:0] prod_scaled;
	always @*
	begin
		// Right shift keeps the sign so a scaled negative product stays negative
		case (product_shift_mode_r) // RULE6
			`DCSD_PSHIFT_NONE: prod_scaled = o_product_hold_r;
			`DCSD_PSHIFT_LEFT1: prod_scaled = {o_product_hold_r[30:0], 1'b0};
			`DCSD_PSHIFT_LEFT4: prod_scaled = {o_product_hold_r[27:0], 4'h0};
			`DCSD_PSHIFT_RIGHT6: prod_scaled = {{6{o_product_hold_r[31]}}, o_product_hold_r[31:6]};
			default: prod_scaled = o_product_hold_r;
		endcase
	end
	// Combinational so the arithmetic unit sees it the same cycle
	assign o_product_scaled = prod_scaled; // RULE7

	// ==========================================
	// Accumulator load with saturation
	// Sign of the true sum picks which end to clamp to
	wire acc_pos = ~i_acc_sum[32];
	wire [31:0] acc_next = (i_acc_overflow && saturate_mode_r) // RULE23
		? (acc_pos ? 32'h7fffffff : 32'h80000000) : i_acc_sum[31:0];

	// ==========================================
	// Output scaler
	wire [31:0] out_shifted = o_acc_r << i_out_shift; // RULE4
	wire [15:0] out_half = i_out_high ? out_shifted[31:16] : out_shifted[15:0]; // RULE5

	// ==========================================
	// Trap vectors: two words per vector
	assign o_trap_vector = {10'h000, i_trap_num, 1'b0}; // RULE20

	// ==========================================
	// Hardware stack
	assign o_stk_empty = (stk_cnt_r == 4'h0);
	assign o_stk_full = (stk_cnt_r == 4'h8);
	// Newest entry sits one below the count; a full count wraps to index seven
	wire [2:0] stk_top_idx = stk_cnt_r[2:0] - 3'h1;
	assign o_stk_top = o_stk_empty ? 16'h0000 : stk_mem_r[stk_top_idx];

	// ==========================================
	// Status write path
	reg [15:0] s0_wr;
	reg [15:0] s1_wr;
	// Bit operations on word zero also reach the irq disable and excess flags
	wire stat_bit_op = (i_stat_op == `DCSD_SOP_SETBIT) || (i_stat_op == `DCSD_SOP_CLRBIT);
	wire stat_bit_op0 = stat_bit_op && !i_stat_sel;
	always @*
	begin
		s0_wr = o_status0;
		s1_wr = o_status1;
		case (i_stat_op)
			`DCSD_SOP_SETBIT:
			begin
				if (i_stat_sel)
					s1_wr[i_stat_bit] = 1'b1; // RULE19
				else
					s0_wr[i_stat_bit] = 1'b1;
			end
			`DCSD_SOP_CLRBIT:
			begin
				if (i_stat_sel)
					s1_wr[i_stat_bit] = 1'b0; // RULE19
				else
					s0_wr[i_stat_bit] = 1'b0;
			end
			default:
			begin
				s0_wr = o_status0;
				s1_wr = o_status1;
			end
		endcase
	end

	// ==========================================
	// Registers
	always @(posedge i_ref_clk)
	begin
		if (i_rst) // RULE25
		begin
			aux_pointer_select_r <= 3'h0;
			aux_pointer_backup_r <= 3'h0;
			arith_excess_flag_r <= 1'b0;
			saturate_mode_r <= 1'b0;
			global_irq_disable_r <= 1'b1; // RULE22
			page_pointer_r <= 9'h000;
			ram_map_select_r <= 1'b0;
			test_condition_flag_r <= 1'b0;
			// Carry, sign extension and external flag come up set
			sign_extend_mode_r <= 1'b1;
			carry_r <= 1'b1;
			external_flag_r <= 1'b1;
			product_shift_mode_r <= 2'h0;
			multiplier_operand_reg_r <= 16'h0000;
			o_product_hold_r <= 32'h00000000;
			o_acc_r <= 32'h00000000;
			o_write_data_r <= 16'h0000;
			o_store_data_r <= 16'h0000;
			o_next_fetch_r <= 16'h0000;
			o_cur_fetch_r <= 16'h0000;
			micro_return_store_r <= 16'h0000;
			stk_cnt_r <= 4'h0;
			for (k = 0; k < `DCSD_STACK_DEPTH; k = k + 1)
				stk_mem_r[k] <= 16'h0000;
		end
		else
		begin
			if (i_opreg_load)
				multiplier_operand_reg_r <= i_opreg_data;
			if (i_mul_go)
				o_product_hold_r <= mul_prod; // RULE2
			o_acc_r <= acc_next;
			o_write_data_r <= out_half; // RULE5
			// Store copies the read image, so reserved bits go out as ones
			if (i_store_status)
				o_store_data_r <= i_stat_sel ? o_status1 : o_status0; // RULE18

			// Program address: PC is next_fetch + 1
			// Restore beats jump and advance so the saved fetch address returns intact
			if (i_retstore_save)
				micro_return_store_r <= o_next_fetch_r; // RULE13
			if (i_retstore_restore)
				o_next_fetch_r <= micro_return_store_r; // RULE13
			else if (i_pa_jump)
				o_next_fetch_r <= i_pa_target;
			else if (i_pa_advance)
				o_next_fetch_r <= o_next_fetch_r + 16'h0001; // RULE11
			if (!i_pa_hold)
				o_cur_fetch_r <= o_next_fetch_r; // RULE10 RULE12

			// Stack: push refused when full, pop when empty; push has priority unless the stack is full, when a pop goes ahead
			if (i_stk_push && !o_stk_full)
			begin
				stk_mem_r[stk_cnt_r[2:0]] <= i_stk_data; // RULE8
				stk_cnt_r <= stk_cnt_r + 4'h1;
			end
			else if (i_stk_pop && !o_stk_empty)
				stk_cnt_r <= stk_cnt_r - 4'h1;

			// Status words
			case (i_stat_op)
				`DCSD_SOP_LOAD0:
				begin
					aux_pointer_select_r <= i_stat_data[`DCSD_S0_PTR_HI:`DCSD_S0_PTR_LO]; // RULE17
					saturate_mode_r <= i_stat_data[`DCSD_S0_SATMODE];
					page_pointer_r <= i_stat_data[`DCSD_S0_PAGE_HI:`DCSD_S0_PAGE_LO];
				end
				`DCSD_SOP_LOAD1:
				begin
					aux_pointer_backup_r <= i_stat_data[`DCSD_S1_BKP_HI:`DCSD_S1_BKP_LO];
					aux_pointer_select_r <= i_stat_data[`DCSD_S1_BKP_HI:`DCSD_S1_BKP_LO];
					ram_map_select_r <= i_stat_data[`DCSD_S1_RAMMAP];
					test_condition_flag_r <= i_stat_data[`DCSD_S1_TEST];
					sign_extend_mode_r <= i_stat_data[`DCSD_S1_SIGNEXT];
					carry_r <= i_stat_data[`DCSD_S1_CARRY];
					external_flag_r <= i_stat_data[`DCSD_S1_EXTFLAG];
					product_shift_mode_r <= i_stat_data[`DCSD_S1_PSHIFT_HI:`DCSD_S1_PSHIFT_LO];
				end
				`DCSD_SOP_PTR:
				begin
					aux_pointer_backup_r <= aux_pointer_select_r; // RULE21
					aux_pointer_select_r <= i_stat_data[2:0];
				end
				`DCSD_SOP_SETBIT, `DCSD_SOP_CLRBIT:
				begin
					aux_pointer_select_r <= s0_wr[`DCSD_S0_PTR_HI:`DCSD_S0_PTR_LO];
					saturate_mode_r <= s0_wr[`DCSD_S0_SATMODE];
					page_pointer_r <= s0_wr[`DCSD_S0_PAGE_HI:`DCSD_S0_PAGE_LO];
					aux_pointer_backup_r <= s1_wr[`DCSD_S1_BKP_HI:`DCSD_S1_BKP_LO];
					ram_map_select_r <= s1_wr[`DCSD_S1_RAMMAP];
					test_condition_flag_r <= s1_wr[`DCSD_S1_TEST];
					sign_extend_mode_r <= s1_wr[`DCSD_S1_SIGNEXT];
					carry_r <= s1_wr[`DCSD_S1_CARRY];
					external_flag_r <= s1_wr[`DCSD_S1_EXTFLAG];
					product_shift_mode_r <= s1_wr[`DCSD_S1_PSHIFT_HI:`DCSD_S1_PSHIFT_LO];
				end
				default:
				begin
					page_pointer_r <= page_pointer_r;
				end
			endcase

			// Irq disable: a maskable trap taken wins over any clear
			if (i_trap_take && i_trap_maskable)
				global_irq_disable_r <= 1'b1; // RULE22
			else if (stat_bit_op0)
				global_irq_disable_r <= s0_wr[`DCSD_S0_IRQDIS]; // RULE17

			// Overflow event beats any clear in the same cycle
			if (i_acc_overflow)
				arith_excess_flag_r <= 1'b1; // RULE24
			else if (i_branch_excess)
				arith_excess_flag_r <= 1'b0;
			else if (i_stat_op == `DCSD_SOP_LOAD0)
				arith_excess_flag_r <= i_stat_data[`DCSD_S0_EXCESS];
			else if (stat_bit_op0)
				arith_excess_flag_r <= s0_wr[`DCSD_S0_EXCESS];
		end
	end

endmodule // dcsd_core
`default_nettype wire

// ---- dv/dcsd_chk.sv ----
// Concurrent checks on the core scaling datapath ports
`timescale 1ns/1ps
`default_nettype none
module dcsd_chk
(
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// Input scaler and multiplier
	input wire logic [15:0] i_in_data,
	input wire logic [4:0] i_in_shift,
	input wire logic i_in_shift_by_opreg,
	input wire logic i_in_sign_ext,
	input wire logic [31:0] o_in_scaled,
	input wire logic i_mul_go,
	input wire logic i_mul_signed,
	input wire logic [15:0] i_mul_data,
	input wire logic [15:0] o_opreg,
	input wire logic [31:0] o_product_hold_r,
	// Status and traps
	input wire logic i_trap_take,
	input wire logic i_trap_maskable,
	input wire logic [2:0] i_stat_op,
	input wire logic i_stat_sel,
	input wire logic [15:0] i_stat_data,
	input wire logic i_store_status,
	input wire logic [15:0] o_store_data_r,
	input wire logic [15:0] o_status0,
	input wire logic [15:0] o_status1
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);
	// ==========================================
	// Datapath
	in_scale_a: assert property (!i_in_shift_by_opreg && !i_in_sign_ext && i_in_shift <= 5'h10 |->
		o_in_scaled == {16'h0, i_in_data} << i_in_shift) else $error("input scaler mismatch");
	mul_unsigned_a: assert property (i_mul_go && !i_mul_signed |=>
		o_product_hold_r == {16'h0, $past(o_opreg)} * {16'h0, $past(i_mul_data)}) else $error("unsigned product");
	mul_signed_a: assert property (i_mul_go && i_mul_signed |=>
		$signed(o_product_hold_r) == $signed($past(o_opreg)) * $signed($past(i_mul_data))) else $error("signed product");
	// ==========================================
	// Status words
	reserved_one_a: assert property (o_status0[10] && (o_status1 & 16'h01ec) == 16'h01ec)
		else $error("reserved bit low");
	load_irq_a: assert property (i_stat_op == 3'h1 && !i_trap_take |=> $stable(o_status0[9]))
		else $error("load changed irq disable");
	trap_irq_a: assert property (i_trap_take && i_trap_maskable |=> o_status0[9])
		else $error("trap left irq enabled");
	ptr_backup_a: assert property (i_stat_op == 3'h5 |=> o_status0[15:13] == $past(i_stat_data[2:0])
		&& o_status1[15:13] == $past(o_status0[15:13])) else $error("pointer backup wrong");
	store_copy_a: assert property (i_store_status |=>
		o_store_data_r == ($past(i_stat_sel) ? $past(o_status1) : $past(o_status0))) else $error("store wrong");
	cover property (i_mul_go && i_mul_signed);
	cover property (i_stat_op == 3'h5);
	cover property (i_trap_take && i_trap_maskable);
endmodule // dcsd_chk
`default_nettype wire

// ---- dv/dcsd_ctl_model.sv ----
// Controller-side model driving the hardware stack requests
`timescale 1ns/1ps
`default_nettype none
module dcsd_ctl_model
(
	// Clock
	input wire logic i_ref_clk,
	// Stack requests
	output logic o_push,
	output logic o_pop,
	output logic [15:0] o_data
);
	initial
	begin
		o_push = 1'h0;
		o_pop = 1'h0;
		o_data = 16'h0;
	end
	// Released data shows the inverse so stale values cannot pass
	task automatic step(input logic p, input logic q, input logic [15:0] d);
		@(negedge i_ref_clk);
		o_push = p;
		o_pop = q;
		o_data = d;
		@(negedge i_ref_clk);
		o_push = 1'h0;
		o_pop = 1'h0;
		o_data = ~d;
	endtask
endmodule // dcsd_ctl_model
`default_nettype wire

// ---- dv/test_dsp_core_scaling_datapath.sv ----
// Self-checking testbench for the core scaling datapath
`timescale 1ns/1ps
`default_nettype none
module test_dsp_core_scaling_datapath;
	logic i_ref_clk, i_rst, i_in_shift_by_opreg, i_in_sign_ext, i_opreg_load, i_mul_go, i_mul_signed, i_acc_overflow;
	logic i_out_high, i_pa_advance, i_pa_hold, i_pa_jump, i_retstore_save, i_retstore_restore, i_trap_take;
	logic i_trap_maskable, i_stat_sel, i_branch_excess, i_store_status;
	logic [15:0] i_in_data, i_opreg_data, i_mul_data, i_pa_target, i_stat_data;
	logic [4:0] i_in_shift, i_trap_num;
	logic [32:0] i_acc_sum;
	logic [2:0] i_out_shift, i_stat_op;
	logic [3:0] i_stat_bit;
	wire logic i_stk_push, i_stk_pop, o_stk_empty, o_stk_full, o_external_flag_pin;
	wire logic [15:0] i_stk_data, o_opreg, o_write_data_r, o_next_fetch_r, o_cur_fetch_r, o_stk_top;
	wire logic [15:0] o_trap_vector, o_store_data_r, o_status0, o_status1;
	wire logic [31:0] o_in_scaled, o_product_hold_r, o_product_scaled, o_acc_r;
	wire logic [3:0] o_bit_index;
	int fails = 0;
	int n_checks = 0;
	dcsd_core dut (.*);
	dcsd_ctl_model m (.i_ref_clk(i_ref_clk), .o_push(i_stk_push), .o_pop(i_stk_pop), .o_data(i_stk_data));
	initial
	begin
		i_ref_clk = 1'h0;
		forever #50 i_ref_clk = ~i_ref_clk;
	end
	// ==========================================
	// Helpers
	task automatic tick;
		@(negedge i_ref_clk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic sop(input logic [2:0] op, input logic sel, input logic [3:0] b, input logic [15:0] d);
		tick;
		i_stat_op = op;
		i_stat_sel = sel;
		i_stat_bit = b;
		i_stat_data = d;
		tick;
		i_stat_op = 3'h0;
		i_stat_data = ~d;
	endtask
	task automatic report_and_stop;
		$display("checks=%0d fails=%0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ==========================================
	// Scenarios
	task automatic t_in;
		int s;
		tick;
		i_in_data = 16'h8001;
		for (s = 0; s <= 16; s++)
		begin
			i_in_shift = s[4:0];
			#1 chk(o_in_scaled, 32'h8001 << s);
			tick;
		end
		i_opreg_load = 1'h1;
		i_opreg_data = 16'h0003;
		tick;
		i_opreg_load = 1'h0;
		i_in_shift_by_opreg = 1'h1;
		#1 chk(o_in_scaled, 32'h00040008);
		chk(o_bit_index, 32'h3);
		tick;
		i_in_sign_ext = 1'h1;
		#1 chk(o_in_scaled, 32'hfffc0008);
		tick;
		i_in_shift_by_opreg = 1'h0;
		i_in_sign_ext = 1'h0;
	endtask
	task automatic t_mul;
		int s;
		int k;
		logic [31:0] p;
		i_opreg_load = 1'h1;
		i_opreg_data = 16'hffff;
		tick;
		i_opreg_load = 1'h0;
		chk(o_opreg, 32'hffff);
		for (s = 1; s >= 0; s--)
		begin
			i_mul_go = 1'h1;
			i_mul_signed = s[0];
			i_mul_data = 16'h0002;
			tick;
			i_mul_go = 1'h0;
			chk(o_product_hold_r, s ? 32'hfffffffe : 32'h0001fffe);
			tick;
		end
		p = 32'h0001fffe;
		for (k = 0; k < 4; k++)
		begin
			sop(3'h2, 1'h1, 4'h0, k[15:0]);
			chk(o_product_scaled, k == 0 ? p : k == 1 ? p << 1 : k == 2 ? p << 4 : p >> 6);
		end
	endtask
	task automatic t_stat;
		sop(3'h1, 1'h0, 4'h0, 16'h0000);
		chk(o_status0, 16'h0600);
		sop(3'h2, 1'h1, 4'h0, 16'h0000);
		chk(o_status1, 16'h01ec);
		chk(o_external_flag_pin, 32'h0);
		sop(3'h3, 1'h0, 4'hb, 16'h0000);
		chk(o_status0, 16'h0e00);
		sop(3'h4, 1'h0, 4'h9, 16'h0000);
		chk(o_status0, 16'h0c00);
		sop(3'h5, 1'h0, 4'h0, 16'h0005);
		chk(o_status0, 16'hac00);
		sop(3'h5, 1'h0, 4'h0, 16'h0003);
		chk(o_status1, 16'ha1ec);
		i_store_status = 1'h1;
		i_stat_sel = 1'h1;
		tick;
		i_store_status = 1'h0;
		chk(o_store_data_r, 16'ha1ec);
		tick;
		i_store_status = 1'h1;
		i_stat_sel = 1'h0;
		tick;
		i_store_status = 1'h0;
		chk(o_store_data_r, 16'h6c00);
		i_trap_take = 1'h1;
		i_trap_maskable = 1'h1;
		i_trap_num = 5'h1f;
		#1 chk(o_trap_vector, 16'h003e);
		tick;
		i_trap_take = 1'h0;
		chk(o_status0, 16'h6e00);
		sop(3'h3, 1'h1, 4'h4, 16'h0000);
		chk(o_external_flag_pin, 32'h1);
		chk(o_status1, 16'ha1fc);
	endtask
	task automatic t_acc;
		i_acc_sum = 33'h0_8000_0000;
		i_acc_overflow = 1'h1;
		i_out_shift = 3'h4;
		i_out_high = 1'h1;
		tick;
		i_acc_overflow = 1'h0;
		i_acc_sum = 33'h0_1234_5678;
		chk(o_acc_r, 32'h7fffffff);
		chk(o_status0, 16'h7e00);
		repeat (2) tick;
		chk(o_write_data_r, 16'h2345);
		i_out_high = 1'h0;
		tick;
		chk(o_write_data_r, 16'h6780);
		chk(o_status0, 16'h7e00);
		i_branch_excess = 1'h1;
		tick;
		i_branch_excess = 1'h0;
		chk(o_status0, 16'h6e00);
		sop(3'h4, 1'h0, 4'hb, 16'h0000);
		i_acc_sum = 33'h0_8000_0000;
		i_acc_overflow = 1'h1;
		tick;
		i_acc_overflow = 1'h0;
		chk(o_acc_r, 32'h80000000);
	endtask
	task automatic t_pa;
		i_pa_jump = 1'h1;
		i_pa_target = 16'h0100;
		tick;
		i_pa_jump = 1'h0;
		i_pa_advance = 1'h1;
		repeat (3) tick;
		i_pa_advance = 1'h0;
		chk(o_next_fetch_r, 16'h0103);
		tick;
		chk(o_cur_fetch_r, 16'h0103);
		i_pa_hold = 1'h1;
		i_retstore_save = 1'h1;
		tick;
		i_retstore_save = 1'h0;
		i_pa_jump = 1'h1;
		i_pa_target = 16'h0200;
		tick;
		i_pa_jump = 1'h0;
		chk(o_cur_fetch_r, 16'h0103);
		i_pa_hold = 1'h0;
		i_retstore_restore = 1'h1;
		tick;
		i_retstore_restore = 1'h0;
		chk(o_next_fetch_r, 16'h0103);
	endtask
	task automatic t_stack;
		int i;
		for (i = 0; i < 9; i++)
			m.step(1'h1, 1'h0, 16'h1000 + i[15:0]);
		chk(o_stk_full, 32'h1);
		for (i = 7; i >= 0; i--)
		begin
			chk(o_stk_top, 16'h1000 + i[15:0]);
			m.step(1'h0, 1'h1, 16'h0000);
		end
		chk(o_stk_empty, 32'h1);
	endtask
	// ==========================================
	// Main sequence and watchdog
	initial
	begin
		i_rst = 1'h1;
		{i_in_shift_by_opreg, i_in_sign_ext, i_opreg_load, i_mul_go, i_mul_signed, i_acc_overflow, i_out_high} = '0;
		{i_pa_advance, i_pa_hold, i_pa_jump, i_retstore_save, i_retstore_restore, i_trap_take, i_trap_maskable} = '0;
		{i_stat_sel, i_branch_excess, i_store_status, i_in_data, i_opreg_data, i_mul_data, i_pa_target} = '0;
		{i_stat_data, i_in_shift, i_trap_num, i_acc_sum, i_out_shift, i_stat_op, i_stat_bit} = '0;
		repeat (12) @(posedge i_ref_clk);
		tick;
		i_rst = 1'h0;
		chk(o_status0, 16'h0600);
		chk(o_status1, 16'h07fc);
		chk(o_external_flag_pin, 32'h1);
		t_in;
		t_mul;
		t_stat;
		t_acc;
		t_pa;
		t_stack;
		report_and_stop;
	end
	initial
	begin
		repeat (2000) @(posedge i_ref_clk);
		fails++;
		report_and_stop;
	end
endmodule // test_dsp_core_scaling_datapath
bind dcsd_core dcsd_chk u_chk (.*);
`default_nettype wire
